//--- include/fps_pkg.sv
// package for the flash program and security block
// assumes a single 125 MHz clock and an external flash macro behind ports
package fps_pkg;
	localparam int          PAGE_BYTES     = 128;
	localparam int          PAGES_16K      = 128;
	localparam int          PAGES_32K      = 256;
	localparam int          ADDR_W         = 16;
	localparam int          PAGE_OFF_W     = 7;
	localparam int          CLK_MHZ        = 125;
	localparam int          PROG_TIME_MS   = 10;
	localparam int          PROG_CYCLES    = PROG_TIME_MS * 1000 * CLK_MHZ;
	// security byte layout
	localparam int          HSB_LJB_POS    = 7;
	localparam int          HSB_X2_POS     = 6;
	localparam int          HSB_AUX_RAM_FUSE_POS   = 5;
	localparam int          HSB_LB2_POS    = 2;
	localparam int          HSB_LB1_POS    = 1;
	localparam int          HSB_LB0_POS    = 0;
	// loader jump programmed (0), x2 and aux_ram_fuse unprogrammed, level four
	localparam logic [7:0]  HSB_DEFAULT    = 8'h7B;
	localparam logic [7:0]  HSB_INACTIVE   = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	localparam logic [1:0]  SRC_PAR        = 2'h0;
	localparam logic [1:0]  SRC_ISP        = 2'h1;
	localparam logic [1:0]  SRC_API        = 2'h2;
	// one-hot levels
	localparam logic [3:0]  LVL1           = 4'h1;
	localparam logic [3:0]  LVL2           = 4'h2;
	localparam logic [3:0]  LVL3           = 4'h4;
	localparam logic [3:0]  LVL4           = 4'h8;
	typedef enum logic [4:0] {
		FPS_IDLE  = 5'h01,
		FPS_ERASE = 5'h02,
		FPS_PROG  = 5'h04,
		FPS_CHIP  = 5'h08,
		FPS_WAIT  = 5'h10
	} fps_state_e;
endpackage : fps_pkg

//--- rtl/fps_flash_security.sv
// flash program sequencer and code protection for an 8-bit controller
// assumes flash array and extra array macros are outside, reached by ports
// parallel programmer pins arrive asynchronous and are synchronised here
module fps_flash_security
	import fps_pkg::*;
#(
	parameter int PROG_CNT = PROG_CYCLES,
	parameter bit BIG_PART = 1'b1
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              ext_access_n_i,
	input  wire logic              fetch_req_i,
	input  wire logic              fetch_ext_code_i,
	input  wire logic              fetch_table_i,
	input  wire logic [ADDR_W-1:0] fetch_addr_i,
	output logic                   fetch_internal_o,
	output logic                   fetch_allowed_o,
	output logic [7:0]             fetch_data_o,
	input  wire logic              par_req_i,
	input  wire logic              par_write_i,
	input  wire logic              par_id_i,
	input  wire logic              par_chip_erase_i,
	input  wire logic              isp_req_i,
	input  wire logic              api_req_i,
	input  wire logic              page_mode_i,
	input  wire logic              xaf_sel_i,
	input  wire logic [ADDR_W-1:0] prog_addr_i,
	input  wire logic [7:0]        prog_data_i,
	input  wire logic              sw_sec_lock_i,
	output logic                   busy_o,
	output logic                   refused_o,
	output logic [7:0]             par_rdata_o,
	input  wire logic [7:0]        part_id_i,
	input  wire logic [7:0]        hsb_prog_i,
	input  wire logic              hsb_prog_we_i,
	output logic [7:0]             hardware_security_byte_o,
	output logic [3:0]             level_o,
	output logic                   ext_access_latched_o,
	input  wire logic [7:0]        flash_rdata_i,
	output logic                   flash_erase_o,
	output logic                   flash_prog_o,
	output logic                   flash_chip_erase_o,
	output logic                   flash_xaf_o,
	output logic [ADDR_W-1:0]      flash_addr_o,
	output logic [7:0]             flash_wdata_o,
	output logic [PAGE_OFF_W:0]    flash_len_o
);
	function automatic logic [3:0] lvl_decode(input logic [7:0] hardware_security_byte);
		logic [3:0] l;
		l = LVL1;
		if (!hardware_security_byte[HSB_LB0_POS])
			l = LVL2;
		if (!hardware_security_byte[HSB_LB1_POS])
			l = LVL3;
		if (!hardware_security_byte[HSB_LB2_POS])
			l = LVL4;
		return l;
	endfunction : lvl_decode

	// pin inputs from the programmer and the access pin
	logic [1:0] ea_s_q, req_s_q, wr_s_q, id_s_q, ce_s_q;
	logic       req_d1_q;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ea_s_q   <= 2'h3;
			req_s_q  <= 2'h0;
			wr_s_q   <= 2'h0;
			id_s_q   <= 2'h0;
			ce_s_q   <= 2'h0;
			req_d1_q <= 1'b0;
		end
		else if (ce_i)
		begin
			ea_s_q   <= {ea_s_q[0], ext_access_n_i};
			req_s_q  <= {req_s_q[0], par_req_i};
			wr_s_q   <= {wr_s_q[0], par_write_i};
			id_s_q   <= {id_s_q[0], par_id_i};
			ce_s_q   <= {ce_s_q[0], par_chip_erase_i};
			req_d1_q <= req_s_q[1];
		end
	end
	logic par_go;
	assign par_go = req_s_q[1] & ~req_d1_q;

	// security state: hsb, sampled level, latched access pin
	logic [7:0] hsb_q, hsb_d;
	logic [3:0] lvl_q, lvl_d;
	logic       ea_q, ea_d;
	// access pin latched only once the synchroniser holds the real pin
	logic [1:0] init_q, init_d;
	logic       erase_done;

	always_comb
	begin
		hsb_d  = hsb_q;
		lvl_d  = lvl_q;
		ea_d   = ea_q;
		init_d = init_q;
		if (init_q != 2'h3)
			init_d = init_q + 2'h1;
		if (init_q == 2'h0)
			lvl_d = lvl_decode(hsb_q);
		if (init_q != 2'h3)
			ea_d = ea_s_q[1];
		if (hsb_prog_we_i)
			hsb_d = hsb_prog_i & hsb_q;
		if (erase_done)
		begin
			hsb_d = HSB_INACTIVE;
			lvl_d = LVL1;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hsb_q  <= HSB_DEFAULT;
			lvl_q  <= LVL4;
			ea_q   <= 1'b1;
			init_q <= 2'h0;
		end
		else if (ce_i)
		begin
			hsb_q  <= hsb_d;
			lvl_q  <= lvl_d;
			ea_q   <= ea_d;
			init_q <= init_d;
		end
	end

	logic lvl2p, lvl3p, lvl4p, ea_eff;
	assign lvl2p  = |lvl_q[3:1];
	assign lvl3p  = |lvl_q[3:2];
	assign lvl4p  = lvl_q[3];
	// above level 1 the pin as seen at reset rules, not the live pin
	assign ea_eff = lvl2p ? ea_q : ea_s_q[1];

	// fetch path: combinational, byte wide, no wait states
	always_comb
	begin
		fetch_internal_o = ea_eff & ~fetch_ext_code_i;
		fetch_allowed_o  = 1'b1;
		if (fetch_ext_code_i && fetch_table_i && lvl2p && ea_eff)
			fetch_allowed_o = 1'b0;
		// top level forbids external code even with the pin held low
		if (fetch_ext_code_i && !fetch_table_i && lvl4p)
			fetch_allowed_o = 1'b0;
		fetch_data_o = (fetch_req_i && fetch_allowed_o) ?
			flash_rdata_i : 8'h00;
	end

	// program sequencer
	fps_state_e st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] data_q, data_d, prd_q, prd_d;
	logic pg_q, pg_d, xaf_q, xaf_d, ref_q, ref_d;
	logic isp_ok, api_ok, par_prog, par_rd;

	assign isp_ok   = isp_req_i & ~(sw_sec_lock_i & ~xaf_sel_i);
	assign api_ok   = api_req_i;
	assign par_prog = par_go & wr_s_q[1] & ~ce_s_q[1];
	assign par_rd   = par_go & ~wr_s_q[1] & ~ce_s_q[1];
	assign erase_done = (st_q == FPS_CHIP) && (cnt_q == 32'h0);

	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		addr_d = addr_q;
		data_d = data_q;
		prd_d  = prd_q;
		pg_d   = pg_q;
		xaf_d  = xaf_q;
		ref_d  = 1'b0;
		unique case (st_q)
			FPS_IDLE:
			begin
				if (par_go && ce_s_q[1])
				begin
					st_d  = FPS_CHIP;
					cnt_d = PROG_CNT - 1;
				end
				else if (par_rd)
				begin
					if (id_s_q[1])
						prd_d = part_id_i;
					else if (lvl3p)
					begin
						prd_d = 8'h00;
						ref_d = 1'b1;
					end
					else
						prd_d = flash_rdata_i;
				end
				else if (par_prog && lvl2p)
					ref_d = 1'b1;
				else if (isp_req_i && !isp_ok)
					ref_d = 1'b1;
				else if (par_prog || isp_ok || api_ok)
				begin
					st_d   = FPS_ERASE;
					addr_d = prog_addr_i;
					data_d = prog_data_i;
					pg_d   = page_mode_i;
					xaf_d  = xaf_sel_i;
					if (page_mode_i)
						addr_d[PAGE_OFF_W-1:0] = '0;
					if (!BIG_PART)
						addr_d[ADDR_W-1] = 1'b0;
					cnt_d = PROG_CNT / 2 - 1;
				end
			end
			FPS_ERASE:
			begin
				if (cnt_q == 32'h0)
				begin
					st_d  = FPS_PROG;
					cnt_d = PROG_CNT - PROG_CNT / 2 - 1;
				end
				else
					cnt_d = cnt_q - 32'h1;
			end
			FPS_PROG, FPS_CHIP:
			begin
				if (cnt_q == 32'h0)
					st_d = FPS_WAIT;
				else
					cnt_d = cnt_q - 32'h1;
			end
			FPS_WAIT:
				st_d = FPS_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q   <= FPS_IDLE;
			cnt_q  <= 32'h0;
			addr_q <= '0;
			data_q <= 8'h00;
			prd_q  <= 8'h00;
			pg_q   <= 1'b0;
			xaf_q  <= 1'b0;
			ref_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			addr_q <= addr_d;
			data_q <= data_d;
			prd_q  <= prd_d;
			pg_q   <= pg_d;
			xaf_q  <= xaf_d;
			ref_q  <= ref_d;
		end
	end

	assign busy_o             = (st_q != FPS_IDLE);
	assign refused_o          = ref_q;
	assign par_rdata_o        = prd_q;
	assign hardware_security_byte_o = hsb_q;
	assign level_o            = lvl_q;
	assign ext_access_latched_o = ea_q;
	assign flash_erase_o      = (st_q == FPS_ERASE);
	assign flash_prog_o       = (st_q == FPS_PROG);
	assign flash_chip_erase_o = (st_q == FPS_CHIP);
	assign flash_xaf_o        = xaf_q;
	assign flash_addr_o       = addr_q;
	assign flash_wdata_o      = data_q;
	// page length 128 in page mode, else a single byte
	assign flash_len_o = pg_q ? (PAGE_OFF_W+1)'(PAGE_BYTES) :
		(PAGE_OFF_W+1)'(1);
endmodule : fps_flash_security

//--- verification/fps_flash_model.sv
// flash macro model: holds the last programmed byte for read back
// assumes one clock shared with the sequencer
module fps_flash_model (
	input  wire logic       clk_i,
	input  wire logic       flash_prog_o,
	input  wire logic       flash_chip_erase_o,
	input  wire logic [7:0] flash_wdata_o,
	output logic      [7:0] flash_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial flash_rdata_i = 8'hC3;
	// one cell only: enough to show a program landed
	always @(posedge clk_i)
		if (flash_chip_erase_o)
			flash_rdata_i <= 8'hFF;
		else if (flash_prog_o)
			flash_rdata_i <= flash_wdata_o;
endmodule : fps_flash_model

//--- verification/fps_flash_security_asserts.sv
// timing checks on the sequencer ports
// assumes bound into every fps_flash_security instance
module fps_flash_security_asserts
	import fps_pkg::*;
#(
	parameter int PROG_CNT = PROG_CYCLES
)
(
	input wire logic clk_i, rst_n_i, ce_i, api_req_i, fetch_req_i,
	input wire logic fetch_ext_code_i, ext_access_n_i, busy_o, refused_o,
	input wire logic fetch_internal_o, fetch_allowed_o, flash_erase_o,
	input wire logic flash_prog_o, flash_chip_erase_o,
	input wire logic [3:0] level_o,
	input wire logic [7:0] fetch_data_o, flash_rdata_i,
	input wire logic [7:0] hardware_security_byte_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	int unsigned run_q, run_d;
	always_comb run_d = busy_o ? run_q + 1 : 0;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			run_q <= 0;
		else
			run_q <= run_d;
	sequence s_take;
		api_req_i && !busy_o && ce_i;
	endsequence
	sequence s_erase;
		busy_o && flash_erase_o && !flash_prog_o;
	endsequence
	a_take_erase: assert property (s_take |=> s_erase)
		else $error("take without erase");
	a_erase_prog: assert property ($rose(flash_prog_o) |->
		$past(flash_erase_o) && busy_o)
		else $error("program not after erase");
	a_busy_len: assert property ($fell(busy_o) && $past(flash_prog_o, 2)
		|-> run_q == PROG_CNT + 1)
		else $error("busy length");
	a_level_hold: assert property ($changed(level_o) |->
		$past(flash_chip_erase_o))
		else $error("level moved");
	a_erase_clear: assert property ($fell(flash_chip_erase_o) |-> ##[0:1]
		(level_o == LVL1 && hardware_security_byte_o == HSB_INACTIVE))
		else $error("chip erase left security");
	a_no_ext_exec: assert property (fetch_req_i && fetch_ext_code_i &&
		level_o == LVL4 |-> !fetch_allowed_o)
		else $error("external run at top level");
	a_read_pass: assert property (fetch_req_i && fetch_allowed_o |->
		fetch_data_o == flash_rdata_i)
		else $error("read data");
	a_ext_only: assert property ((level_o == LVL1 && !ext_access_n_i)[*3]
		|-> !fetch_internal_o)
		else $error("internal fetch with pin low");
	a_refuse_once: assert property (refused_o |=> !refused_o)
		else $error("refuse pulse long");
endmodule : fps_flash_security_asserts

bind fps_flash_security fps_flash_security_asserts
	#(.PROG_CNT(PROG_CNT)) u_chk (.*);

//--- verification/tb.sv
// directed bench for the flash sequencer, short program count
// assumes the flash macro model stands on the far side
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fps_pkg::*;
	localparam int PC = 20;
	logic clk_i = 0, rst_n_i = 0, ce_i = 1, ext_access_n_i = 1;
	logic fetch_req_i = 1, fetch_ext_code_i = 0, fetch_table_i = 0;
	logic par_req_i = 0, par_write_i = 0, par_id_i = 0, isp_req_i = 0;
	logic par_chip_erase_i = 0, api_req_i = 0, page_mode_i = 0;
	logic xaf_sel_i = 0, sw_sec_lock_i = 0, hsb_prog_we_i = 0;
	logic [15:0] fetch_addr_i = 0, prog_addr_i = 0, flash_addr_o;
	logic [7:0] prog_data_i = 0, part_id_i = 8'h5A, hsb_prog_i = 8'hFF;
	logic [7:0] fetch_data_o, par_rdata_o, hardware_security_byte_o;
	logic [7:0] flash_rdata_i, flash_wdata_o, flash_len_o;
	logic [3:0] level_o;
	logic fetch_internal_o, fetch_allowed_o, busy_o, refused_o, r, sb;
	logic ext_access_latched_o, flash_erase_o, flash_prog_o, flash_xaf_o;
	logic flash_chip_erase_o;
	int miscompares = 0, total_checks = 0, cyc = 0, n;
	fps_flash_security #(.PROG_CNT(PC)) DUT (.*);
	fps_flash_model u_mem (.*);
	always #4 clk_i = ~clk_i;
	task automatic chk(input logic [15:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic conclude;
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// one-cycle pulse; returns with r = refused, n = busy cycles
	task automatic run(input logic isp);
		@(posedge clk_i);
		{isp_req_i, api_req_i} <= {isp, !isp};
		@(posedge clk_i);
		{isp_req_i, api_req_i} <= 2'h0;
		#1;
		r = refused_o;
		n = 0;
		while (busy_o === 1'b1)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask : run
	// pins are synced inside, so hold them several cycles
	task automatic par(input logic w, id, ce);
		{r, sb} = 2'h0;
		@(posedge clk_i);
		{par_write_i, par_id_i, par_chip_erase_i, par_req_i} <= {w, id, ce, 1'b1};
		repeat (6)
		begin
			@(posedge clk_i);
			#1;
			{r, sb} = {r | refused_o, sb | busy_o};
		end
		par_req_i <= 0;
		while (busy_o !== 1'b0) @(posedge clk_i);
	endtask : par
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			miscompares++;
			conclude();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1;
		{prog_addr_i, prog_data_i} <= {16'h0123, 8'hA5};
		repeat (3) @(posedge clk_i);
		{ext_access_n_i, fetch_ext_code_i} <= 2'h1;
		repeat (4) @(posedge clk_i);
		#1;
		chk(hardware_security_byte_o, HSB_DEFAULT);
		chk(level_o, LVL4);
		chk(fetch_allowed_o, 0);
		chk(fetch_internal_o, 0);
		chk(ext_access_latched_o, 1);
		@(posedge clk_i);
		{ext_access_n_i, fetch_ext_code_i} <= 2'h2;
		run(1);
		chk(n, PC + 1);
		chk(fetch_data_o, 8'hA5);
		sw_sec_lock_i <= 1;
		run(1);
		chk(r, 1);
		{xaf_sel_i, page_mode_i} <= 2'h3;
		run(0);
		chk(flash_addr_o, 16'h0100);
		chk(flash_len_o, 8'h80);
		chk(flash_xaf_o, 1);
		chk(n, PC + 1);
		par(1, 0, 0);
		chk(r, 1);
		par(0, 0, 0);
		chk(r, 1);
		chk(par_rdata_o, 0);
		par(0, 1, 0);
		chk(par_rdata_o, 8'h5A);
		par(0, 0, 1);
		chk(hardware_security_byte_o, HSB_INACTIVE);
		chk(level_o, LVL1);
		par(1, 0, 0);
		chk({r, sb}, 2'h1);
		@(posedge clk_i);
		ext_access_n_i <= 0;
		repeat (5) @(posedge clk_i);
		#1;
		chk(fetch_internal_o, 0);
		conclude();
	end
endmodule : tb
